// *** inc/timer_pkg.sv ***
package timer_pkg;

    // ----------------------------------------------------------------
    // channel control byte fields
    // ----------------------------------------------------------------
    localparam int CTRL_IRQ_EN     = 7;  // interrupt on zero count
    localparam int CTRL_MODE       = 6;  // 0 timer, 1 counter
    localparam int CTRL_PRESCALE   = 5;  // 0 divide by short, 1 by long
    localparam int CTRL_SLOPE      = 4;  // 1 rising trigger edge is active
    localparam int CTRL_TRIG_MODE  = 3;  // 1 timer waits for a trigger edge
    localparam int CTRL_TC_FOLLOWS = 2;  // next byte is a time constant
    localparam int CTRL_SW_RESET   = 1;  // halt the channel
    localparam int CTRL_IS_CONTROL = 0;  // marks a control byte

    localparam logic [7:0] CTRL_RESET = 8'h00;  // interrupts off, timer mode

    // ----------------------------------------------------------------
    // vector byte layout and prescaler
    // ----------------------------------------------------------------
    localparam int VEC_BASE_LSB    = 3;  // upper five bits kept by software
    localparam int NUM_CHANNELS    = 4;
    localparam int PRESCALE_SHORT  = 16;
    localparam int PRESCALE_LONG   = 256;

    // channel sequencer, gray coded along idle, armed, start, run
    typedef enum logic [1:0] {
        CH_IDLE  = 2'b00,
        CH_ARMED = 2'b01,
        CH_START = 2'b11,
        CH_RUN   = 2'b10
    } chan_state_e;

    // a time constant byte of zero stands for a full 256 count
    function automatic logic [8:0] tc_count(input logic [7:0] tc_byte);
        tc_count = (tc_byte == 8'h00) ? 9'h100 : {1'b0, tc_byte};
    endfunction : tc_count

endpackage : timer_pkg

// *** rtl/timer_channel.sv ***
`timescale 1ns/1ps
module timer_channel (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       wr_pulse,     // byte written to this channel
    input  wire logic [7:0] wr_data,
    input  wire logic       trig_pin,     // raw count_trigger_input pin
    input  wire logic       tick_short,   // prescaler enables
    input  wire logic       tick_long,
    output logic            expect_tc,    // next byte is a time constant
    output logic            zero_pulse,   // one cycle at each zero count
    output logic            irq_enable
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]              control;     // channel_control register
    logic [7:0]              time_const;  // last time constant byte
    logic [8:0]              count;       // down-counter, up to 256
    timer_pkg::chan_state_e  state;
    logic                    trig_meta;   // synchroniser first stage
    logic                    trig_sync;
    logic                    trig_last;   // for edge detection
    logic                    ctrl_wr;
    logic                    tc_wr;
    logic                    slope_flip;
    logic                    active_edge;
    logic                    timer_mode;
    logic                    tick;
    logic                    decrement;

    // a byte is a time constant only when announced
    assign tc_wr      = wr_pulse & expect_tc;
    // any other byte with bit 0 set is a control byte
    assign ctrl_wr    = wr_pulse & ~expect_tc & wr_data[timer_pkg::CTRL_IS_CONTROL];
    // changing the slope bit acts as an edge
    assign slope_flip = ctrl_wr & (wr_data[timer_pkg::CTRL_SLOPE]
                                   ^ control[timer_pkg::CTRL_SLOPE]);
    assign active_edge = (control[timer_pkg::CTRL_SLOPE] ? (trig_sync & ~trig_last)
                                                         : (~trig_sync & trig_last))
                         | slope_flip;
    assign timer_mode = ~control[timer_pkg::CTRL_MODE];
    // prescale choice only matters in timer mode
    assign tick       = control[timer_pkg::CTRL_PRESCALE] ? tick_long : tick_short;
    assign decrement  = (state == timer_pkg::CH_RUN) & (timer_mode ? tick : active_edge);
    assign irq_enable = control[timer_pkg::CTRL_IRQ_EN];

    // ----------------------------------------------------------------
    // trigger pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_last <= 1'b0;
        end else begin
            trig_meta <= trig_pin;
            trig_sync <= trig_meta;
            trig_last <= trig_sync;
        end
    end

    // control byte; software reset still updates the other bits
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            control <= timer_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            control <= wr_data;
        end
    end

    // time-constant-follows flag
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            expect_tc <= 1'b0;
        end else if (tc_wr) begin
            expect_tc <= 1'b0;
        end else if (ctrl_wr) begin
            expect_tc <= wr_data[timer_pkg::CTRL_TC_FOLLOWS];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            time_const <= 8'h00;
        end else if (tc_wr) begin
            time_const <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // sequencer: halt on software reset, start on constant or trigger
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= timer_pkg::CH_IDLE;
        end else if (ctrl_wr && wr_data[timer_pkg::CTRL_SW_RESET]) begin
            state <= timer_pkg::CH_IDLE;
        end else begin
            unique case (state)
                timer_pkg::CH_IDLE: begin
                    // waiting channel resumes once its constant lands
                    if (tc_wr) begin
                        if (!timer_mode)
                            state <= timer_pkg::CH_RUN;
                        else if (control[timer_pkg::CTRL_TRIG_MODE])
                            state <= timer_pkg::CH_ARMED;
                        else
                            state <= timer_pkg::CH_START;
                    end
                end
                timer_pkg::CH_ARMED: begin
                    if (active_edge)
                        state <= timer_pkg::CH_START;
                end
                // one clock of setup before the first decrement
                timer_pkg::CH_START: state <= timer_pkg::CH_RUN;
                timer_pkg::CH_RUN:   state <= timer_pkg::CH_RUN;
            endcase
        end
    end

    // down-counter; a running channel takes a new constant only at zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 9'h000;
        end else if (tc_wr && state == timer_pkg::CH_IDLE) begin
            count <= timer_pkg::tc_count(wr_data);
        end else if (decrement) begin
            if (count == 9'h001)
                count <= timer_pkg::tc_count(time_const);
            else
                count <= count - 9'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            zero_pulse <= 1'b0;
        end else begin
            zero_pulse <= decrement & (count == 9'h001);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    zc_reload_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        zero_pulse |-> count == timer_pkg::tc_count($past(time_const)))
        else $error("counter did not reload the constant at zero");
    sw_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ctrl_wr && wr_data[timer_pkg::CTRL_SW_RESET]) |=> state == timer_pkg::CH_IDLE)
        else $error("software reset did not halt the channel");
    auto_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (tc_wr && state == timer_pkg::CH_IDLE && timer_mode
         && !control[timer_pkg::CTRL_TRIG_MODE])
        |=> state == timer_pkg::CH_START ##1 state == timer_pkg::CH_RUN)
        else $error("timer did not start on its own after the constant");
    trig_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state == timer_pkg::CH_ARMED && !active_edge && !wr_pulse)
        |=> state == timer_pkg::CH_ARMED)
        else $error("triggered timer started without an edge");
    idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state == timer_pkg::CH_IDLE) |=> !zero_pulse)
        else $error("halted channel reached zero");

endmodule : timer_channel

// *** rtl/counter_timer_unit.sv ***
// What this block does
// - constant accepted only after announcing control byte
// - running count finishes before new constant loads
// - one shared vector, channel number inserted
// - bit 0 set means control byte
// - vector written to channel 0, bit 0 clear
// - two select inputs pick the channel
// - hardware reset halts, disables, quiets outputs
// - bit 1 halts channel, other bits update
// - halt plus follow flag waits for constant
// - auto-trigger timer starts after constant load
// - bit 7 enables interrupt on zero
// - bit 6 picks timer or counter mode
// - bit 5 picks prescale 16 or 256
// - bit 2 announces a following constant
// - bit 4 edge; changing it is an edge
// - triggered timer starts one clock after edge
// - constant zero means 256
`timescale 1ns/1ps
module counter_timer_unit #(
    parameter int CHANNELS = 4
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic                write_strobe,        // one-cycle byte write
    input  wire logic [7:0]          write_data,
    input  wire logic                channel_select_high,
    input  wire logic                channel_select_low,
    input  wire logic [CHANNELS-1:0] count_trigger_input, // asynchronous pins
    input  wire logic                int_ack,             // one-cycle acknowledge
    input  wire logic                daisy_chain_in,
    output logic [CHANNELS-1:0]      zero_count_output,
    output logic                     interrupt_request,
    output logic                     daisy_chain_out,
    output logic [7:0]               vector_data,
    output logic                     vector_oe
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // the vector byte only has room for a two-bit channel number
    if (CHANNELS != timer_pkg::NUM_CHANNELS) begin : g_bad_channels
        $error("counter_timer_unit supports exactly four channels");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]          prescale;       // free-running system clock divider
    logic                tick_short;     // one cycle every 16 clocks
    logic                tick_long;      // one cycle every 256 clocks
    logic [1:0]          select;         // decoded channel number
    logic [CHANNELS-1:0] chan_wr;        // write routed per channel
    logic [CHANNELS-1:0] expect_tc;      // channel wants a constant next
    logic [CHANNELS-1:0] zero_pulse;
    logic [CHANNELS-1:0] irq_enable;
    logic [4:0]          vector_base;    // upper five vector bits
    logic                vector_wr;
    logic [CHANNELS-1:0] pending;        // sticky zero-count requests
    logic [CHANNELS-1:0] next_pending;
    logic [CHANNELS-1:0] ack_clear;
    logic                ack_take;       // acknowledge actually served
    logic [1:0]          ack_chan;

    // lowest channel number wins the acknowledge
    function automatic logic [1:0] first_pending(input logic [3:0] req);
        first_pending = req[0] ? 2'h0 : req[1] ? 2'h1 : req[2] ? 2'h2 : 2'h3;
    endfunction : first_pending

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // shared across channels, so a timer's first period may be short by
    // up to one prescale period; cheaper than one divider per channel
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale <= 8'h00;
        end else begin
            prescale <= prescale + 8'h01;
        end
    end

    // enables registered so each is exactly one cycle wide
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_short <= 1'b0;
            tick_long  <= 1'b0;
        end else begin
            tick_short <= prescale[3:0] == 4'(timer_pkg::PRESCALE_SHORT - 1);
            tick_long  <= prescale == 8'(timer_pkg::PRESCALE_LONG - 1);
        end
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    // host logic shares ref_clk, so the bus needs no synchroniser
    assign select = {channel_select_high, channel_select_low};

    // vector: channel 0, bit 0 clear, not an expected constant
    assign vector_wr = write_strobe & (select == 2'h0) & ~expect_tc[0]
                       & ~write_data[timer_pkg::CTRL_IS_CONTROL];

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
        // each write goes only to the selected channel
        assign chan_wr[i] = write_strobe & (select == 2'(i));

        timer_channel u_channel (
            .ref_clk    (ref_clk),
            .reset_n    (reset_n),
            .wr_pulse   (chan_wr[i]),
            .wr_data    (write_data),
            .trig_pin   (count_trigger_input[i]),
            .tick_short (tick_short),
            .tick_long  (tick_long),
            .expect_tc  (expect_tc[i]),
            .zero_pulse (zero_pulse[i]),
            .irq_enable (irq_enable[i])
        );
    end

    // zero-count pins come straight from each channel's pulse flop
    assign zero_count_output = zero_pulse;

    // ----------------------------------------------------------------
    // shared interrupt vector
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            vector_base <= 5'h00;
        end else if (vector_wr) begin
            vector_base <= write_data[7:timer_pkg::VEC_BASE_LSB];
        end
    end

    // ----------------------------------------------------------------
    // interrupt requests and acknowledge
    // ----------------------------------------------------------------
    // an acknowledge is served only while this unit holds priority
    assign ack_take  = int_ack & daisy_chain_in & (|pending);
    assign ack_chan  = first_pending(pending);
    assign ack_clear = ack_take ? (CHANNELS'(1) << ack_chan) : '0;

    // a zero count in the same cycle as its clear keeps the request
    always_comb begin
        next_pending = (pending & ~ack_clear) | (zero_pulse & irq_enable);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // request is masked while a higher device holds the chain
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_request <= 1'b0;
        end else begin
            interrupt_request <= daisy_chain_in & (|next_pending);
        end
    end

    // chain passes priority on only while nothing here is pending;
    // resets high since the idle chain input is high
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            daisy_chain_out <= 1'b1;
        end else begin
            daisy_chain_out <= daisy_chain_in & ~(|next_pending);
        end
    end

    // vector drive: base bits plus the serviced channel number
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            vector_data <= 8'h00;
            vector_oe   <= 1'b0;
        end else if (ack_take) begin
            vector_data <= {vector_base, ack_chan, 1'b0};
            vector_oe   <= 1'b1;
        end else begin
            vector_oe   <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    vector_ack_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ack_take |=> vector_oe && vector_data[7:3] == $past(vector_base)
                     && vector_data[2:1] == $past(ack_chan) && !vector_data[0])
        else $error("vector byte wrong after acknowledge");
    ack_prio_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ack_take && pending[0]) |=> vector_data[2:1] == 2'h0 ##1 (!vector_oe || $past(ack_take)))
        else $error("channel 0 did not win the acknowledge");
    vector_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        vector_wr |=> vector_base == $past(write_data[7:3]))
        else $error("vector base not stored");
    daisy_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (|next_pending) |=> !daisy_chain_out)
        else $error("chain passed while a request is pending");

endmodule : counter_timer_unit

// *** tb/host_cpu_model.sv ***
`timescale 1ns/1ps
// ------
// host side of the byte write port
// ------
module host_cpu_model (
    input  wire logic  ref_clk,
    output logic       write_strobe,        // one pulse per byte
    output logic [7:0] write_data,
    output logic       channel_select_high,
    output logic       channel_select_low,
    output logic       int_ack,             // one-cycle acknowledge
    output logic       daisy_chain_in       // priority from devices higher up the chain
);
    // quiet bus at time zero
    initial begin
        write_strobe = 1'b0;
        write_data = 8'h00;
        channel_select_high = 1'b0;
        channel_select_low = 1'b0;
        int_ack = 1'b0;
        daisy_chain_in = 1'b1;
    end
    // idle data shows the inverse so a stale byte never looks valid
    task automatic write_byte(input logic [1:0] ch, input logic [7:0] data);
        @(posedge ref_clk);
        write_strobe <= 1'b1;
        write_data <= data;
        {channel_select_high, channel_select_low} <= ch;
        @(posedge ref_clk);
        write_strobe <= 1'b0;
        write_data <= ~data;
    endtask : write_byte
    // every programming is a control byte announcing the constant, then it
    task automatic program_channel(input logic [1:0] ch, input logic [7:0] ctrl,
                                   input logic [7:0] tc);
        write_byte(ch, ctrl | 8'h05);
        write_byte(ch, tc);
    endtask : program_channel
    // vector always goes to channel 0 with bit 0 clear
    task automatic write_vector(input logic [4:0] base);
        write_byte(2'b00, {base, 3'b000});
    endtask : write_vector
    // a higher device taking or giving back the chain priority
    task automatic set_chain(input logic level);
        @(posedge ref_clk);
        daisy_chain_in <= level;
    endtask : set_chain
    // acknowledge held for exactly one sampling edge
    task automatic ack();
        @(posedge ref_clk);
        int_ack <= 1'b1;
        @(posedge ref_clk);
        int_ack <= 1'b0;
    endtask : ack
endmodule : host_cpu_model

// *** tb/four_channel_counter_timer_programming_bench.sv ***
`timescale 1ns/1ps
module four_channel_counter_timer_programming_bench;
    logic       ref_clk, reset_n, strobe, sel_h, sel_l, ack_w, dci, dco, irq, voe;
    logic [7:0] wdata, vdata;
    logic [3:0] trig, zc;
    int         fail_count, num_checks, seed, cyc, p, h, t1, t2;
    int         last[4], prev[4], hits[4];  // zero pulse times and counts
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;
    counter_timer_unit #(.CHANNELS(4)) counter_timer_unit_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .write_strobe(strobe), .write_data(wdata),
        .channel_select_high(sel_h), .channel_select_low(sel_l), .count_trigger_input(trig),
        .int_ack(ack_w), .daisy_chain_in(dci), .zero_count_output(zc),
        .interrupt_request(irq), .daisy_chain_out(dco), .vector_data(vdata), .vector_oe(voe));
    host_cpu_model host_cpu_model_inst (.ref_clk(ref_clk), .write_strobe(strobe),
        .write_data(wdata), .channel_select_high(sel_h), .channel_select_low(sel_l),
        .int_ack(ack_w), .daisy_chain_in(dci));
    // log every zero pulse so periods come from time stamps
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 4; i++) begin
            if (zc[i] === 1'b1) begin
                prev[i] <= last[i];
                last[i] <= cyc;
                hits[i] <= hits[i] + 1;
            end
        end
    end
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // model: interval is prescale times constant, zero meaning 256
    function automatic int period_of(input int pre, input int tc);
        return pre * ((tc == 0) ? 256 : tc);
    endfunction : period_of
    // bounded wait for the next zero pulse of a channel
    task automatic wait_zero(input int ch, output int per);
        int n;
        n = hits[ch];
        for (int k = 0; k < 10000 && hits[ch] == n; k++) tick();
        // a channel that never reaches zero must not pass on a stale period
        if (hits[ch] == n) begin
            fail_count++;
            $display("Error at %0t got %h expected %h", $time, hits[ch], n + 1);
        end
        per = last[ch] - prev[ch];
    endtask : wait_zero
    // trigger pulse long enough to pass the synchroniser
    task automatic edge_pulse(input int ch);
        @(posedge ref_clk) trig[ch] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        trig[ch] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : edge_pulse
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    // ------
    // main sequence
    // ------
    initial begin
        seed = 44763;
        reset_n = 1'b0;
        trig = 4'h0;
        repeat (10) @(posedge ref_clk);
        #1;
        chk(zc, 4'h0);
        chk(irq, 1'b0);
        chk(dco, 1'b1);
        chk(voe, 1'b0);
        @(posedge ref_clk) reset_n <= 1'b1;
        tick();
        t1 = 1 + ($unsigned($random(seed)) % 4);
        t2 = 1 + ($unsigned($random(seed)) % 4);
        host_cpu_model_inst.program_channel(2'b01, 8'h05, t1[7:0]);
        wait_zero(1, p);
        wait_zero(1, p);
        chk(p, period_of(16, t1));
        host_cpu_model_inst.program_channel(2'b01, 8'h05, t2[7:0]);
        wait_zero(1, p);
        chk(p, period_of(16, t1));
        wait_zero(1, p);
        chk(p, period_of(16, t2));
        host_cpu_model_inst.write_byte(2'b01, 8'h03);
        tick();
        tick();
        h = hits[1];
        repeat (600) tick();
        chk(hits[1], h);
        // triggered timer waits for its edge before it runs
        host_cpu_model_inst.program_channel(2'b01, 8'h1D, 8'h02);
        h = hits[1];
        repeat (100) tick();
        chk(hits[1], h);
        edge_pulse(1);
        wait_zero(1, p);
        wait_zero(1, p);
        chk(p, period_of(16, 2));
        host_cpu_model_inst.program_channel(2'b00, 8'h25, 8'h01);
        wait_zero(0, p);
        wait_zero(0, p);
        chk(p, period_of(256, 1));
        host_cpu_model_inst.program_channel(2'b11, 8'h05, 8'h00);
        wait_zero(3, p);
        wait_zero(3, p);
        chk(p, period_of(16, 0));
        host_cpu_model_inst.program_channel(2'b10, 8'h55, 8'h03);
        h = hits[2];
        repeat (2) edge_pulse(2);
        chk(hits[2], h);
        edge_pulse(2);
        chk(hits[2], h + 1);
        host_cpu_model_inst.write_vector(5'h15);
        host_cpu_model_inst.program_channel(2'b10, 8'hD7, 8'h01);
        edge_pulse(2);
        chk(irq, 1'b1);
        chk(dco, 1'b0);
        host_cpu_model_inst.ack();
        #1;
        chk(voe, 1'b1);
        chk(vdata, {5'h15, 2'h2, 1'b0});
        // acknowledge with nothing pending gets no answer
        host_cpu_model_inst.ack();
        #1;
        chk(voe, 1'b0);
        chk(dco, 1'b1);
        // with nothing pending the chain output follows the chain input
        host_cpu_model_inst.set_chain(1'b0);
        tick();
        chk(dco, 1'b0);
        chk(irq, 1'b0);
        host_cpu_model_inst.set_chain(1'b1);
        tick();
        chk(dco, 1'b1);
        h = hits[2];
        host_cpu_model_inst.write_byte(2'b10, 8'hC1);
        repeat (6) tick();
        chk(hits[2], h + 1);
        print_verdict();
    end
    // watchdog sized well past the longest sequence
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        print_verdict();
    end
endmodule : four_channel_counter_timer_programming_bench
